// ===== tft_timing_defs.svh
// Purpose: Offsets, fields, reset values and pulse counts of the TFT timing block
// Assumes: Included by bare name from the package and the design
// Notes:   Pulse counts are in pixel clocks or lines
`ifndef TFT_TIMING_DEFS_SVH
`define TFT_TIMING_DEFS_SVH

`define OFF_PANEL    8'h0C
`define OFF_HTOTAL   8'h20
`define OFF_HDISP    8'h24
`define OFF_HSTART   8'h28
`define OFF_LINE     8'h2C
`define OFF_VTOTAL   8'h30
`define OFF_VDISP    8'h34
`define OFF_FRAME    8'h3C
`define OFF_CTRL     8'h40
`define OFF_STATUS   8'h44

`define IDX_PANEL    4'h0
`define IDX_HTOTAL   4'h1
`define IDX_HDISP    4'h2
`define IDX_HSTART   4'h3
`define IDX_LINE     4'h4
`define IDX_VTOTAL   4'h5
`define IDX_VDISP    4'h6
`define IDX_FRAME    4'h7
`define IDX_CTRL     4'h8
`define IDX_STATUS   4'h9
`define IDX_NONE     4'hF
`define RW_COUNT     4'h9

`define MASK_PANEL   32'h0000_0003
`define MASK_H7      32'h0000_007F
`define MASK_P10     32'h0000_03FF
`define MASK_LINE    32'h00FF_03FF
`define MASK_FRAME   32'h0087_03FF
`define MASK_CTRL    32'h0000_0001
`define REG_RESET    32'h0000_0000

`define PANEL_MSB    1
`define PANEL_LSB    0
`define H7_MSB       6
`define P10_MSB      9
`define HPW_MSB      22
`define HPW_LSB      16
`define VPW_MSB      18
`define VPW_LSB      16
`define POL_BIT      23
`define DIRECT_BIT   0

`define HPS_ADD      11'h001
`define DISPLAY_START_POSITION_ADD     11'h005
`define TOTAL_ADD    8'h01
`define HPW_ADD      8'h01
`define VPW_ADD      4'h1
`define DE_MAX       11'h0FA

`define S_LEAD       11'h004
`define S3_DELAY     11'h004
`define S_WIDTH      11'h088
`define S2_LEAD      11'h00A
`define ALT1_START   11'h005
`define ALT1_LINES   11'h004
`define ALT0_START   11'h028
`define ALT0_LINES   11'h0A2
`define ALT1_PULSE   11'h030
`define ALT1_GAP     11'h028
`define ALT0_LOW     11'h018

`endif

// ===== tft_timing_pkg.sv
// Purpose: Types shared by the TFT timing block
// Assumes: Nothing beyond the defs header
// Notes:   Frame, line, enable and strobe pins travel together as one struct
`include "tft_timing_defs.svh"
package tft_timing_pkg;
	typedef enum logic [1:0] {
		PANEL_PASSIVE = 2'b00,
		PANEL_TFT     = 2'b01,
		PANEL_RSVD2   = 2'b10,
		PANEL_RSVD3   = 2'b11
	} panel_kind_type;

	typedef struct packed {
		logic       frameSync;
		logic       lineSync;
		logic       dataEnableStrobe;
		logic [3:0] strobe;
	} panel_out_type;
endpackage

// ===== tft_panel_timing_generator.sv
// Purpose: TFT frame, line, shift clock and data-enable timing with
//          direct-drive panel strobes, registers over AHB-Lite
// Assumes: PIX_DIV >= 2; one clock; pixel source on the same clock
// Notes:   In TFT mode, panel pins other than the shift clock change only on the pixel enable
`include "tft_timing_defs.svh"
module tft_panel_timing_generator #(
	parameter int unsigned PIX_DIV = 2,
	parameter int unsigned DATA_W  = 18
) (
	// System
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// AHB-Lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [31:0]                        hrdata,
	// Pixel source
	input  wire logic [DATA_W-1:0]             pixelData,
	output logic                               pixelTake,
	// Panel
	output logic                               shiftClock,
	output tft_timing_pkg::panel_out_type      panel,
	output logic [DATA_W-1:0]                  panelData
);
	import tft_timing_pkg::*;

	logic [31:0] regs [0:8];
	logic        wrPend;
	logic [3:0]  wrIdx;
	logic [3:0]  addrIdx;
	logic        addrTake;
	logic [31:0] rdValue;
	logic [7:0]  divCnt;
	logic [7:0]  next_divCnt;
	logic        pixEn;
	logic [10:0] hCount;
	logic [10:0] vCount;
	logic        hEnd;
	logic        vEnd;
	logic [10:0] htClk;
	logic [10:0] vtLines;
	logic [10:0] line_start_position;
	logic [10:0] display_start_position;
	logic [10:0] display_period;
	logic [10:0] frame_start_line;
	logic [7:0]  line_pulse_width;
	logic [3:0]  frame_pulse_lines;
	logic        linePol;
	logic        framePol;
	logic        tftMode;
	logic        directDrive;
	logic [10:0] lineRise;
	logic [10:0] frameFall;
	logic [10:0] hStrOff;
	logic [10:0] hS2Off;
	logic [10:0] vAltOff;
	logic        lineAct;
	logic        frameAct;
	logic        deAct;
	logic        alt1;
	logic        alt0;
	logic        win136;
	logic        s1Alt;
	logic        s0Alt;
	logic        s2Hit;

	// Distance from b forward to a, modulo t
	function automatic logic [10:0] wrapDiff(input logic [10:0] a, input logic [10:0] b,
		input logic [10:0] t);
		logic [11:0] d;
		d = {1'b0, a} - {1'b0, b};
		if (d[11]) begin
			d = d + {1'b0, t};
		end
		return d[10:0];
	endfunction

	function automatic logic [10:0] wrapSum(input logic [10:0] a, input logic [10:0] b,
		input logic [10:0] t);
		logic [11:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, t}) begin
			s = s - {1'b0, t};
		end
		return s[10:0];
	endfunction

	// Upper address bits alias; unmapped offsets read zero
	function automatic logic [3:0] decode(input logic [7:0] off);
		case (off)
			`OFF_PANEL:  return `IDX_PANEL;
			`OFF_HTOTAL: return `IDX_HTOTAL;
			`OFF_HDISP:  return `IDX_HDISP;
			`OFF_HSTART: return `IDX_HSTART;
			`OFF_LINE:   return `IDX_LINE;
			`OFF_VTOTAL: return `IDX_VTOTAL;
			`OFF_VDISP:  return `IDX_VDISP;
			`OFF_FRAME:  return `IDX_FRAME;
			`OFF_CTRL:   return `IDX_CTRL;
			`OFF_STATUS: return `IDX_STATUS;
			default:     return `IDX_NONE;
		endcase
	endfunction

	function automatic logic [31:0] regMask(input logic [3:0] idx);
		case (idx)
			`IDX_PANEL:  return `MASK_PANEL;
			`IDX_HTOTAL: return `MASK_H7;
			`IDX_HDISP:  return `MASK_H7;
			`IDX_LINE:   return `MASK_LINE;
			`IDX_FRAME:  return `MASK_FRAME;
			`IDX_CTRL:   return `MASK_CTRL;
			default:     return `MASK_P10;
		endcase
	endfunction

	// Bus: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addrTake  = hsel && hready && htrans[1];
	assign addrIdx   = decode(haddr[7:0]);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend <= 1'b0;
			wrIdx  <= `IDX_NONE;
		end else begin
			wrPend <= addrTake && hwrite && (addrIdx < `RW_COUNT);
			wrIdx  <= addrIdx;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 9; i++) begin
				regs[i] <= `REG_RESET;
			end
		end else if (wrPend) begin
			regs[wrIdx] <= hwdata & regMask(wrIdx);
		end
	end

	// Read right behind a write to the same word sees the new data
	always_comb begin
		rdValue = 32'h0000_0000;
		if (addrIdx == `IDX_STATUS) begin
			rdValue = {5'h00, vCount, 5'h00, hCount};
		end else if (addrIdx < `RW_COUNT) begin
			if (wrPend && wrIdx == addrIdx) begin
				rdValue = hwdata & regMask(addrIdx);
			end else begin
				rdValue = regs[addrIdx];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (addrTake && !hwrite) begin
			hrdata <= rdValue;
		end
	end

	// Decoded timing fields
	assign tftMode     = regs[`IDX_PANEL][`PANEL_MSB:`PANEL_LSB] == PANEL_TFT;
	assign htClk       = {({1'b0, regs[`IDX_HTOTAL][`H7_MSB:0]} + `TOTAL_ADD), 3'b000};
	assign display_period         = {({1'b0, regs[`IDX_HDISP][`H7_MSB:0]} + `TOTAL_ADD), 3'b000};
	assign line_start_position         = {1'b0, regs[`IDX_LINE][`P10_MSB:0]} + `HPS_ADD;
	assign display_start_position        = {1'b0, regs[`IDX_HSTART][`P10_MSB:0]} + `DISPLAY_START_POSITION_ADD;
	assign line_pulse_width         = {1'b0, regs[`IDX_LINE][`HPW_MSB:`HPW_LSB]} + `HPW_ADD;
	assign vtLines     = {1'b0, regs[`IDX_VTOTAL][`P10_MSB:0]} + `HPS_ADD;
	assign frame_start_line         = {1'b0, regs[`IDX_FRAME][`P10_MSB:0]};
	assign frame_pulse_lines         = {1'b0, regs[`IDX_FRAME][`VPW_MSB:`VPW_LSB]} + `VPW_ADD;
	assign linePol     = regs[`IDX_LINE][`POL_BIT];
	assign framePol    = regs[`IDX_FRAME][`POL_BIT];
	assign directDrive = regs[`IDX_CTRL][`DIRECT_BIT];

	// Pixel enable divider and shift clock
	assign pixEn       = tftMode && (divCnt == 8'(PIX_DIV - 1));
	assign next_divCnt = pixEn ? 8'h00 : divCnt + 8'h01;

	always_ff @(posedge clk) begin
		if (!rst_n || !tftMode) begin
			divCnt <= 8'h00;
		end else begin
			divCnt <= next_divCnt;
		end
	end

	// Rises with each data change, falls mid-pixel where the panel samples
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shiftClock <= 1'b0;
		end else begin
			shiftClock <= tftMode && (next_divCnt < 8'(PIX_DIV / 2));
		end
	end

	// Raster counters; >= lets a shrunk total recover at once
	assign hEnd = hCount >= htClk - 11'h001;
	assign vEnd = vCount >= vtLines - 11'h001;

	always_ff @(posedge clk) begin
		if (!rst_n || !tftMode) begin
			hCount <= 11'h000;
			vCount <= 11'h000;
		end else if (pixEn) begin
			if (hEnd) begin
				hCount <= 11'h000;
				vCount <= vEnd ? 11'h000 : vCount + 11'h001;
			end else begin
				hCount <= hCount + 11'h001;
			end
		end
	end

	// Pulse windows, all modulo the totals
	assign lineAct  = wrapDiff(hCount, line_start_position, htClk) < {3'h0, line_pulse_width};
	assign deAct    = wrapDiff(hCount, display_start_position, htClk) < display_period;
	assign frameAct = wrapDiff(vCount, frame_start_line, vtLines) < {7'h00, frame_pulse_lines};
	// Frame changes at pixel 0, so line edge trails it by the line start
	assign lineRise  = linePol ? line_start_position : wrapSum(line_start_position, {3'h0, line_pulse_width}, htClk);
	assign frameFall = framePol ? wrapSum(frame_start_line, {7'h00, frame_pulse_lines}, vtLines) : frame_start_line;
	assign hStrOff   = wrapDiff(hCount, wrapDiff(lineRise, `S_LEAD, htClk), htClk);
	assign hS2Off    = wrapDiff(hCount, wrapDiff(lineRise, `S2_LEAD, htClk), htClk);
	assign vAltOff   = wrapDiff(vCount, frameFall, vtLines);
	assign s2Hit     = pixEn && directDrive && (hS2Off == 11'h000);
	assign win136    = hStrOff < `S_WIDTH;
	assign alt1      = vAltOff >= `ALT1_START && vAltOff < `ALT1_START + `ALT1_LINES;
	assign alt0      = vAltOff >= `ALT0_START && vAltOff < `ALT0_START + `ALT0_LINES;
	assign s1Alt     = hStrOff < `ALT1_PULSE || (hStrOff >= `ALT1_PULSE + `ALT1_GAP &&
		hStrOff < `ALT1_PULSE + `ALT1_PULSE + `ALT1_GAP);
	assign s0Alt     = hStrOff < `ALT0_LOW;

	// Panel pins; pin equals activity when the polarity bit is one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			panel <= '0;
		end else if (!tftMode) begin
			panel.frameSync        <= ~framePol;
			panel.lineSync         <= ~linePol;
			panel.dataEnableStrobe <= 1'b0;
			panel.strobe           <= 4'h0;
		end else if (pixEn) begin
			panel.frameSync        <= frameAct ~^ framePol;
			panel.lineSync         <= lineAct ~^ linePol;
			panel.dataEnableStrobe <= deAct;
			if (directDrive) begin
				panel.strobe[3] <= hStrOff == `S_LEAD + `S3_DELAY;
				panel.strobe[1] <= alt1 ? s1Alt : win136;
				panel.strobe[0] <= alt0 ? ~s0Alt : ~win136;
				if (s2Hit) begin
					panel.strobe[2] <= ~panel.strobe[2];
				end
			end else begin
				panel.strobe <= 4'h0;
			end
		end
	end

	// Source hands over a pixel with each enabled display pixel
	assign pixelTake = pixEn && deAct;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			panelData <= '0;
		end else if (pixEn) begin
			panelData <= deAct ? pixelData : '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_vt_wrap;
		pixEn && hEnd && vCount == vtLines - 11'h001 |=> vCount == 11'h000;
	endproperty
	a_vt_wrap: assert property (p_vt_wrap) else $error("vertical count did not wrap");

	property p_ht_wrap;
		pixEn && hCount == htClk - 11'h001 && vtLines != 11'h001 |=> hCount == 11'h000 && vCount != $past(vCount);
	endproperty
	a_ht_wrap: assert property (p_ht_wrap) else $error("horizontal wrap wrong");

	property p_frame_start;
		pixEn && hCount == 11'h000 && vCount == frame_start_line |=> panel.frameSync == framePol;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame pulse start");

	property p_frame_end;
		pixEn && {7'h00, frame_pulse_lines} < vtLines && vCount == wrapSum(frame_start_line, {7'h00, frame_pulse_lines}, vtLines)
			|=> panel.frameSync != framePol;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame pulse width");

	property p_line_start;
		pixEn && hCount == line_start_position |=> panel.lineSync == linePol;
	endproperty
	a_line_start: assert property (p_line_start) else $error("line pulse start");

	property p_line_end;
		pixEn && {3'h0, line_pulse_width} < htClk && hCount == wrapSum(line_start_position, {3'h0, line_pulse_width}, htClk)
			|=> panel.lineSync != linePol;
	endproperty
	a_line_end: assert property (p_line_end) else $error("line pulse width");

	property p_de_start;
		pixEn && hCount == display_start_position |=> panel.dataEnableStrobe;
	endproperty
	a_de_start: assert property (p_de_start) else $error("enable start");

	property p_de_end;
		pixEn && display_period < htClk && hCount == wrapSum(display_start_position, display_period, htClk) |=> !panel.dataEnableStrobe;
	endproperty
	a_de_end: assert property (p_de_end) else $error("enable period");

	property p_shift;
		$changed(panel.dataEnableStrobe) && $past(tftMode) |-> $past(pixEn) && shiftClock ##1 !shiftClock;
	endproperty
	a_shift: assert property (p_shift) else $error("enable not aligned to shift");

	property p_mode;
		!tftMode |=> hCount == 11'h000 && !panel.dataEnableStrobe && !pixelTake;
	endproperty
	a_mode: assert property (p_mode) else $error("timing ran outside TFT mode");

	property p_strobe3;
		directDrive && pixEn && hStrOff == `S_LEAD + `S3_DELAY |=> panel.strobe[3];
	endproperty
	a_strobe3: assert property (p_strobe3) else $error("strobe 3 position");

	property p_strobe2;
		$changed(panel.strobe[2]) && tftMode && $past(tftMode) |-> $past(s2Hit);
	endproperty
	a_strobe2: assert property (p_strobe2) else $error("strobe 2 toggled off position");

	c_frame: cover property (pixEn && hEnd && vEnd);
	c_alt1: cover property (directDrive && alt1 && pixEn && hStrOff == `ALT1_PULSE + `ALT1_GAP);
	c_de_fall: cover property ($fell(panel.dataEnableStrobe));
endmodule

// ===== panel_model.sv
// Purpose: Panel side model that listens to the timing pins
// Assumes: Pins are sampled on the shift clock falling edge
// Notes:   m holds line figures, edge positions and frame totals
module panel_model (
	// Panel pins
	input  wire logic                          shiftClock,
	input  wire tft_timing_pkg::panel_out_type panel,
	// Measurements
	output logic [15:0]                        m [0:14]
);
	timeunit 1ns;
	timeprecision 100ps;
	import tft_timing_pkg::*;
	panel_out_type p = '0;
	logic [15:0]   px = '0;
	logic [15:0]   n;
	logic [15:0]   cl [0:1] = '{default: '0};
	logic [15:0]   cf [0:4] = '{default: '0};
	logic [4:0]    ev;
	logic          lr;
	logic          ff;
	logic          sk = 1'b0;
	function automatic logic [15:0] b(input logic v);
		return {15'h0000, v};
	endfunction
	initial m = '{default: '0};
	// Positions count from the line pin low-to-high edge
	// Power-up step from unknown to low is no sample edge
	always @(posedge shiftClock) sk = 1'b1;
	always @(negedge shiftClock iff sk) begin
		lr = panel.lineSync & ~p.lineSync;
		ff = ~panel.frameSync & p.frameSync;
		ev[0] = panel.dataEnableStrobe & ~p.dataEnableStrobe;
		ev[1] = panel.strobe[3] & ~p.strobe[3];
		ev[2] = panel.strobe[1] & ~p.strobe[1] & ~panel.strobe[0] & p.strobe[0];
		ev[3] = ~panel.strobe[0] & p.strobe[0];
		ev[4] = panel.strobe[2] ^ p.strobe[2];
		if (lr) begin
			m[0] = px + 16'h0001;
			m[1] = cl[0];
			m[2] = cl[1];
			cl = '{default: '0};
		end
		n = lr ? 16'h0000 : px + 16'h0001;
		for (int k = 0; k < 5; k++)
			if (ev[k])
				m[3 + k] = n;
		if (ff) begin
			m[13] = n;
			for (int k = 0; k < 5; k++)
				m[8 + k] = cf[k];
			cf = '{default: '0};
		end
		cl[0] += b(panel.lineSync);
		cl[1] += b(panel.dataEnableStrobe);
		cf[0] += b(lr);
		cf[1] += b(~panel.frameSync);
		cf[2] += b(panel.strobe[1] & ~p.strobe[1]);
		cf[3] += b(panel.strobe[1]);
		cf[4] += b(~panel.strobe[0]);
		m[14] += 16'h0001;
		px = n;
		p = panel;
	end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the TFT panel timing generator
// Assumes: Zero wait state bus slave; pixel clock is clk/2
// Notes:   Line and frame figures are worked out for two setups
`include "tft_timing_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                          clk = 1'b0;
	logic                          rst_n = 1'b0;
	logic                          hsel = 1'b0;
	logic                          hwrite = 1'b0;
	logic                          mv = 1'b0;
	logic                          rp = 1'b0;
	logic [31:0]                   haddr = '0;
	logic [31:0]                   hwdata = '0;
	logic [31:0]                   v;
	logic [1:0]                    htrans = '0;
	logic [2:0]                    hsize = 3'h2;
	logic [17:0]                   pixelData = '0;
	logic                          hreadyout;
	logic                          hresp;
	logic                          pixelTake;
	logic                          shiftClock;
	logic [31:0]                   hrdata;
	logic [17:0]                   panelData;
	tft_timing_pkg::panel_out_type panel;
	logic [15:0]                   m [0:14];
	logic [31:0]                   q [$];
	logic [17:0]                   pq [$];
	logic [17:0]                   pe;
	logic                          pt = 1'b0;
	logic [3:0]                    mi = '0;
	integer                        seed = 32'h3F61;
	int                            fails = 0;
	int                            samples_checked = 0;
	logic [7:0]  off [0:10] = '{`OFF_STATUS, 8'h50, `OFF_HTOTAL, `OFF_HDISP, `OFF_HSTART, `OFF_LINE,
		`OFF_VTOTAL, `OFF_VDISP, `OFF_FRAME, `OFF_CTRL, `OFF_PANEL};
	logic [31:0] msk [0:10] = '{32'h0, 32'h0, `MASK_H7, `MASK_H7, `MASK_P10, `MASK_LINE, `MASK_P10,
		`MASK_P10, `MASK_FRAME, `MASK_CTRL, `MASK_PANEL};
	logic [7:0]  cfo [0:7] = '{`OFF_PANEL, `OFF_HTOTAL, `OFF_HDISP, `OFF_HSTART, `OFF_LINE, `OFF_VTOTAL,
		`OFF_FRAME, `OFF_CTRL};
	// Display periods kept in steps of eight pixels
	logic [31:0] cfg [0:1][0:7] = '{'{32'h0, 32'h3, 32'h1, 32'h9, 32'h10002, 32'h5, 32'h10002, 32'h0},
		'{32'h0, 32'h18, 32'h13, 32'h0, 32'h81000C, 32'h2F, 32'h810000, 32'h1}};
	// FFFF marks a figure that this setup leaves unchecked
	logic [15:0] ex [0:1][0:13] = '{'{16'h20, 16'h1E, 16'h10, 16'h9, 16'hFFFF, 16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'h6, 16'h40, 16'h0, 16'h0, 16'hC0, 16'h1B}, '{16'hC8, 16'h2, 16'hA0, 16'hC0, 16'h4,
		16'hC4, 16'hC4, 16'hBE, 16'h30, 16'h23F0, 16'h34, 16'h18E0, 16'h1600, 16'hBB}};

	tft_panel_timing_generator #(.PIX_DIV(2), .DATA_W(18)) i_dut (
		.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .pixelData(pixelData), .pixelTake(pixelTake), .shiftClock(shiftClock),
		.panel(panel), .panelData(panelData));
	panel_model i_panel (.shiftClock(shiftClock), .panel(panel), .m(m));

	always #5 clk = ~clk;
	// Every pixel handed over is noted for the data check
	always @(posedge clk) begin
		if (pixelTake)
			pq.push_back(pixelData);
		pixelData <= 18'($random(seed));
	end

	task automatic cmp(input logic [31:0] got);
		logic [31:0] e;
		e = q.pop_front();
		samples_checked++;
		if (got !== e) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, e);
		end
	endtask
	// Read data and model figures are compared as they appear
	always @(posedge clk) begin
		if (rp | mv)
			cmp(rp ? hrdata : {16'h0000, m[mi]});
		rp <= hsel & hreadyout & htrans[1] & ~hwrite;
	end
	// A taken pixel stands on panelData, with the enable, one clock later
	always @(posedge clk) begin
		if (rst_n && pt !== (shiftClock & panel.dataEnableStrobe)) begin
			fails++;
			$display("mismatch at %0t: pixel take out of step with enable", $time);
		end
		if (rp && hresp !== 1'b0) begin
			fails++;
			$display("mismatch at %0t: bus response not OKAY", $time);
		end
		if (pt) begin
			pe = pq.pop_front();
			samples_checked++;
			if (panelData !== pe) begin
				fails++;
				$display("mismatch at %0t: panel data %h expected %h", $time, panelData, pe);
			end
		end
		pt <= pixelTake;
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pchk(input logic [3:0] i, input logic [15:0] e);
		q.push_back({16'h0000, e});
		@(posedge clk);
		mi <= i;
		mv <= 1'b1;
		@(posedge clk);
		mv <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 11; k++)
			rd(off[k], 32'h0);
		$display("test reset values done");
		// Only type 01 may run the counters
		for (int t = 0; t < 4; t++) begin
			if (t != 1) begin
				bus(1'b1, `OFF_PANEL, t);
				repeat (50) @(posedge clk);
				pchk(4'hE, 16'h0);
			end
		end
		$display("test panel types done");
		for (int k = 0; k < 11; k++) begin
			v = $random(seed);
			bus(1'b1, off[k], v);
			rd(off[k], v & msk[k]);
		end
		$display("test register access done");
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 8; k++)
				bus(1'b1, cfo[k], cfg[c][k]);
			bus(1'b1, `OFF_PANEL, 32'h1);
			repeat (c == 0 ? 2000 : 58000) @(posedge clk);
			for (int i = 0; i < 14; i++)
				if (ex[c][i] !== 16'hFFFF)
					pchk(4'(i), ex[c][i]);
			$display("test timing setup %0d done", c);
		end
		close_out();
	end
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		close_out();
	end
endmodule
